// ---- logic/uart_device_end.sv ----
// Purpose: baud generation, loopback, address-wait, break and low power of the serial port
// Assumes: inputs synchronous to hclk, registers reached over the control link
// Notes: parity and interrupt vectoring handled elsewhere
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "uart_baud_defines.svh"
module uart_device_end
(
	uart_ctl_if.device_end link,
	input wire logic serial_input_pin,
	input wire logic external_serial_clock_pin,
	output logic serial_output_pin,
	output logic rx_irq,
	output logic tx_irq
);
	import uart_baud_pkg::*;

	uart_baud_pkg::reg_data_t serial_main_control_reg;
	uart_baud_pkg::reg_data_t serial_irq_control_reg;
	uart_baud_pkg::reg_data_t prescaler_select_reg;
	uart_baud_pkg::reg_data_t baud_div_lo;
	uart_baud_pkg::reg_data_t tx_holding_buffer;
	uart_baud_pkg::reg_data_t rx_holding_buffer;
	uart_baud_pkg::reg_data_t wake_enable_reg;
	uart_baud_pkg::reg_data_t wake_edge_reg;
	uart_baud_pkg::reg_data_t read_mux;
	logic tx_buffer_empty_flag;
	logic rx_buffer_full_flag;
	logic rx_ninth_bit;
	logic framing_err;
	logic overrun_err;
	logic address_wait_bit;
	logic wr_hit;
	logic rd_rx_holding_buffer;
	logic bitop_rxstat;
	logic [4:0] pre_code;
	logic [5:0] pre_acc;
	logic [5:0] pre_sum;
	logic [5:0] pre_thr;
	logic pre_tick;
	logic x16_tick;
	logic ext_prev;
	logic ext_rise;
	logic tx_src;
	logic rx_src;
	logic tx_bit_tick;
	logic [3:0] final_m1;
	logic [3:0] half_m1;
	logic [3:0] data_bits;
	logic [3:0] frame_m1;
	logic [11:0] frame;
	logic [11:0] tx_shift_register;
	logic [3:0] tx_cnt;
	logic tx_load;
	logic tx_line;
	logic loopback;
	logic rx_in;
	logic [8:0] rx_shift_register;
	logic [3:0] rx_ph;
	logic [3:0] rx_cnt;
	logic rx_stop_sample;
	logic rx_done;
	logic [7:0] rx_data;
	logic rx9;
	logic asleep;
	logic in_prev;
	tx_state_t tx_state;
	rx_state_t rx_state;

	assign wr_hit = link.req && link.wr;
	assign rd_rx_holding_buffer = link.req && !link.wr && link.addr == `REG_RXHOLD;
	assign bitop_rxstat = wr_hit && link.bitop && link.addr == `REG_RXSTAT;
	assign loopback = serial_main_control_reg[`MAIN_CHL_LO] && serial_main_control_reg[`MAIN_CHL_HI];

	// Software registers, read-only flags kept apart
	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
		begin
			serial_main_control_reg <= `BYTE_RESET;
			serial_irq_control_reg <= `BYTE_RESET;
			prescaler_select_reg <= `BYTE_RESET;
			baud_div_lo <= `BYTE_RESET;
			tx_holding_buffer <= `BYTE_RESET;
			wake_enable_reg <= `BYTE_RESET;
			wake_edge_reg <= `BYTE_RESET;
		end
		else if (wr_hit)
		begin
			unique case (link.addr)
				`REG_MAIN: serial_main_control_reg <= link.wdata & `MAIN_RW_MASK;
				`REG_IRQCTL: serial_irq_control_reg <= link.wdata;
				`REG_PRESCALE: prescaler_select_reg <= link.wdata;
				`REG_BAUDLO: baud_div_lo <= link.wdata;
				`REG_TXHOLD: tx_holding_buffer <= link.wdata;
				`REG_WAKEEN: wake_enable_reg <= link.wdata;
				`REG_WAKEEDG: wake_edge_reg <= link.wdata;
				default: ;
			endcase
		end
	end

	always_comb
	begin
		read_mux = `BYTE_RESET;
		unique case (link.addr)
			`REG_MAIN:
			begin
				read_mux = serial_main_control_reg;
				read_mux[`MAIN_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag;
				read_mux[`MAIN_RX_BUFFER_FULL_FLAG] = rx_buffer_full_flag;
			end
			`REG_RXSTAT:
			begin
				read_mux[`RXS_RX9] = rx_ninth_bit;
				read_mux[`RXS_FRAME_ERR] = framing_err;
				read_mux[`RXS_OVERRUN] = overrun_err;
				read_mux[`RXS_ADDRESS_WAIT_BIT] = address_wait_bit;
			end
			`REG_IRQCTL: read_mux = serial_irq_control_reg;
			`REG_PRESCALE: read_mux = prescaler_select_reg;
			`REG_BAUDLO: read_mux = baud_div_lo;
			`REG_TXHOLD: read_mux = tx_holding_buffer;
			`REG_RXHOLD: read_mux = rx_holding_buffer;
			`REG_WAKEEN: read_mux = wake_enable_reg;
			`REG_WAKEEDG: read_mux = wake_edge_reg;
			default: read_mux = `BYTE_RESET;
		endcase
	end

	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
		begin
			link.ack <= 1'b0;
			link.rdata <= `BYTE_RESET;
		end
		else
		begin
			link.ack <= link.req;
			if (link.req && !link.wr)
				link.rdata <= read_mux;
		end
	end

	// Half-step prescaler: add two per clock, wrap at code+1
	assign pre_code = prescaler_select_reg[4:0];
	assign pre_thr = {1'b0, pre_code} + 6'h01;
	assign pre_sum = pre_acc + `PRE_STEP;

	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
		begin
			pre_acc <= 6'h00;
			pre_tick <= 1'b0;
		end
		else if (pre_code == 5'h00)
		begin
			pre_acc <= 6'h00;
			pre_tick <= 1'b0;
		end
		else if (pre_sum >= pre_thr)
		begin
			pre_acc <= pre_sum - pre_thr;
			pre_tick <= 1'b1;
		end
		else
		begin
			pre_acc <= pre_sum;
			pre_tick <= 1'b0;
		end
	end

	// Divide by N, field holds N-1
	reload_counter #(.WIDTH(11)) divisor_counter
	(
		.hclk(link.hclk),
		.hresetn(link.hresetn),
		.step(pre_tick),
		.stop(pre_code == 5'h00),
		.reload({prescaler_select_reg[7:5], baud_div_lo}),
		.tick(x16_tick)
	);

	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
			ext_prev <= 1'b0;
		else
			ext_prev <= external_serial_clock_pin;
	end

	assign ext_rise = external_serial_clock_pin && !ext_prev;
	assign tx_src = serial_irq_control_reg[`IRQ_TX_EXT] ? ext_rise : x16_tick;
	assign rx_src = serial_irq_control_reg[`IRQ_RX_EXT] ? ext_rise : x16_tick;
	assign final_m1 = serial_irq_control_reg[`IRQ_SYNC] ? `SYNC_DIV_M1 : `ASYNC_DIV_M1;
	assign half_m1 = serial_irq_control_reg[`IRQ_SYNC] ? `SYNC_HALF : `ASYNC_HALF;

	reload_counter #(.WIDTH(4)) tx_final_div
	(
		.hclk(link.hclk),
		.hresetn(link.hresetn),
		.step(tx_src),
		.stop(link.sleep_enter),
		.reload(final_m1),
		.tick(tx_bit_tick)
	);

	// Nine data bits whenever the high length bit is set, loopback included
	assign data_bits = serial_main_control_reg[`MAIN_CHL_HI] ? 4'h9 :
		(serial_main_control_reg[`MAIN_CHL_LO] ? 4'h7 : 4'h8);
	assign frame_m1 = data_bits + (serial_main_control_reg[`MAIN_TWO_STOP] ? 4'h2 : 4'h1);

	always_comb
	begin
		frame = 12'hFFF;
		frame[0] = 1'b0;
		unique case (data_bits)
			4'h7: frame[7:1] = tx_holding_buffer[6:0];
			4'h8: frame[8:1] = tx_holding_buffer;
			default: frame[9:1] = {serial_main_control_reg[`MAIN_TX9], tx_holding_buffer};
		endcase
	end

	assign tx_load = tx_state == TX_IDLE && !tx_buffer_empty_flag && tx_bit_tick && !link.sleep_enter;
	assign tx_line = tx_state == TX_SHIFT ? tx_shift_register[0] : 1'b1;

	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
		begin
			tx_state <= TX_IDLE;
			tx_shift_register <= 12'hFFF;
			tx_cnt <= 4'h0;
		end
		else if (link.sleep_enter)
		begin
			tx_state <= TX_IDLE;
			tx_shift_register <= 12'hFFF;
		end
		else if (tx_load)
		begin
			tx_state <= TX_SHIFT;
			tx_shift_register <= frame;
			tx_cnt <= frame_m1;
		end
		else if (tx_state == TX_SHIFT && tx_bit_tick)
		begin
			tx_shift_register <= {1'b1, tx_shift_register[11:1]};
			if (tx_cnt == 4'h0)
				tx_state <= TX_IDLE;
			else
				tx_cnt <= tx_cnt - 4'h1;
		end
	end

	// Hardware set wins over the software clear
	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
			tx_buffer_empty_flag <= 1'b1;
		else if (link.sleep_enter || tx_load)
			tx_buffer_empty_flag <= 1'b1;
		else if (wr_hit && link.addr == `REG_TXHOLD)
			tx_buffer_empty_flag <= 1'b0;
	end

	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
			serial_output_pin <= 1'b1;
		else if (serial_irq_control_reg[`IRQ_BREAK])
			serial_output_pin <= 1'b0;
		else
			serial_output_pin <= loopback ? 1'b1 : tx_line;
	end

	// Receiver
	assign rx_in = loopback ? tx_line : serial_input_pin;
	assign rx_stop_sample = rx_state == RX_STOP && rx_src && rx_ph == final_m1;
	assign rx9 = serial_main_control_reg[`MAIN_CHL_HI] && rx_shift_register[8];
	assign rx_done = rx_stop_sample && (!address_wait_bit || rx9);
	assign rx_data = serial_main_control_reg[`MAIN_CHL_HI] ? rx_shift_register[7:0] :
		(serial_main_control_reg[`MAIN_CHL_LO] ? {1'b0, rx_shift_register[8:2]} : rx_shift_register[8:1]);

	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
		begin
			rx_state <= RX_IDLE;
			rx_ph <= 4'h0;
			rx_cnt <= 4'h0;
			rx_shift_register <= 9'h000;
		end
		else if (link.sleep_enter)
			rx_state <= RX_IDLE;
		else
		begin
			unique case (rx_state)
				RX_IDLE:
				begin
					rx_ph <= 4'h0;
					if (!rx_in)
						rx_state <= RX_START;
				end
				RX_START:
				begin
					if (rx_src && rx_ph == half_m1)
					begin
						rx_ph <= 4'h0;
						rx_cnt <= 4'h0;
						rx_state <= rx_in ? RX_IDLE : RX_DATA;
					end
					else if (rx_src)
						rx_ph <= rx_ph + 4'h1;
				end
				RX_DATA:
				begin
					if (rx_src && rx_ph == final_m1)
					begin
						rx_ph <= 4'h0;
						rx_shift_register <= {rx_in, rx_shift_register[8:1]};
						if (rx_cnt == data_bits - 4'h1)
							rx_state <= RX_STOP;
						else
							rx_cnt <= rx_cnt + 4'h1;
					end
					else if (rx_src)
						rx_ph <= rx_ph + 4'h1;
				end
				RX_STOP:
				begin
					if (rx_stop_sample)
						rx_state <= RX_IDLE;
					else if (rx_src)
						rx_ph <= rx_ph + 4'h1;
				end
			endcase
		end
	end

	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
			rx_holding_buffer <= `BYTE_RESET;
		else if (rx_done && !link.sleep_enter)
			rx_holding_buffer <= rx_data;
	end

	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
		begin
			rx_buffer_full_flag <= 1'b0;
			rx_ninth_bit <= 1'b0;
		end
		else if (link.sleep_enter)
		begin
			rx_buffer_full_flag <= 1'b0;
			rx_ninth_bit <= 1'b0;
		end
		else if (rx_done)
		begin
			rx_buffer_full_flag <= 1'b1;
			rx_ninth_bit <= rx9;
		end
		else if (rd_rx_holding_buffer)
			rx_buffer_full_flag <= 1'b0;
	end

	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
		begin
			framing_err <= 1'b0;
			overrun_err <= 1'b0;
		end
		else if (link.sleep_enter)
		begin
			framing_err <= 1'b0;
			overrun_err <= 1'b0;
		end
		else if (rx_done)
		begin
			framing_err <= framing_err || !rx_in;
			overrun_err <= overrun_err || (rx_buffer_full_flag && !rd_rx_holding_buffer);
		end
		else if (bitop_rxstat)
		begin
			framing_err <= 1'b0;
			overrun_err <= 1'b0;
		end
	end

	// Software re-arm wins over the automatic clear
	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
			address_wait_bit <= 1'b0;
		else if (wr_hit && link.addr == `REG_RXSTAT)
			address_wait_bit <= link.wdata[`RXS_ADDRESS_WAIT_BIT];
		else if (rx_done && rx9)
			address_wait_bit <= 1'b0;
	end

	// Wake relies on software arming bit 3 for a falling edge
	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
		begin
			asleep <= 1'b0;
			in_prev <= 1'b1;
			link.wake <= 1'b0;
		end
		else
		begin
			in_prev <= serial_input_pin;
			link.wake <= 1'b0;
			if (link.sleep_enter)
				asleep <= 1'b1;
			else if (asleep && in_prev && !serial_input_pin && wake_enable_reg[`WAKE_RX_BIT]
				&& wake_edge_reg[`WAKE_RX_BIT])
			begin
				asleep <= 1'b0;
				link.wake <= 1'b1;
			end
		end
	end

	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
		begin
			rx_irq <= 1'b0;
			tx_irq <= 1'b0;
		end
		else
		begin
			rx_irq <= rx_buffer_full_flag && serial_irq_control_reg[`IRQ_RX_EN];
			tx_irq <= tx_buffer_empty_flag && serial_irq_control_reg[`IRQ_TX_EN];
		end
	end
endmodule // uart_device_end

// ---- logic/uart_baud_defines.svh ----
// Purpose: constants shared by both ends of the serial port control link
// Assumes: 250 MHz hclk, byte-wide device registers, AHB-Lite word map on the host end
// Notes: Behaviour list below, tags used at the implementing logic
//
// Behaviour
// - async bit rate is 16x clock over 16
// - 5-bit prescale code, half steps, zero stops
// - bit rate is 2*Fc/(16*N*P)
// - divisor field holds N-1, divide by N
// - sync mode final divide by two
// - async rates up to 15625k supported
// - low power entry: set tx empty, clear read-only
// - low power entry: tx shifter all ones
// - start bit wakes from halt or idle
// - software enables wake bit 3, falling edge
// - both length bits set: internal loopback
// - loopback uses nine bits, no parity
// - address-wait bit selects address-wait receive
// - ninth bit one means address
// - address-wait drops data, address sets full
// - address character clears address-wait bit
// - software re-arms address-wait or leaves clear
// - tx unaffected, ninth bit in/out registers
// - bit operation on rx status clears errors
// - break bit holds serial output low
// - 11-bit divisor, top bits in prescale register
// - prescale code zero is power down
// - tx and rx clock source chosen independently
`ifndef UART_BAUD_DEFINES_SVH
`define UART_BAUD_DEFINES_SVH

`define REG_MAIN 4'h0
`define REG_RXSTAT 4'h1
`define REG_IRQCTL 4'h2
`define REG_PRESCALE 4'h3
`define REG_BAUDLO 4'h4
`define REG_TXHOLD 4'h5
`define REG_RXHOLD 4'h6
`define REG_WAKEEN 4'h7
`define REG_WAKEEDG 4'h8

`define BYTE_RESET 8'h00
`define MAIN_RW_MASK 8'h3C
`define MAIN_TX_BUFFER_EMPTY_FLAG 0
`define MAIN_RX_BUFFER_FULL_FLAG 1
`define MAIN_TX9 2
`define MAIN_CHL_LO 3
`define MAIN_CHL_HI 4
`define MAIN_TWO_STOP 5
`define RXS_RX9 0
`define RXS_FRAME_ERR 1
`define RXS_OVERRUN 2
`define RXS_ADDRESS_WAIT_BIT 3
`define IRQ_RX_EN 0
`define IRQ_TX_EN 1
`define IRQ_SYNC 2
`define IRQ_BREAK 3
`define IRQ_TX_EXT 4
`define IRQ_RX_EXT 5
`define WAKE_RX_BIT 3

`define ASYNC_DIV_M1 4'hF
`define SYNC_DIV_M1 4'h1
`define ASYNC_HALF 4'h7
`define SYNC_HALF 4'h0
`define PRE_STEP 6'h02

`define HOST_CMD 8'h00
`define HOST_STATUS 8'h04
`define HOST_CTRL 8'h08
`define CMD_WRITE 16
`define CMD_BITOP 17
`define STAT_BUSY 8
`define STAT_WAKE 9

`endif

// ---- logic/uart_baud_pkg.sv ----
// Purpose: types shared by the serial port control ends
// Assumes: nothing beyond SystemVerilog
// Notes: constants live in the defines header
package uart_baud_pkg;
	typedef logic [3:0] reg_addr_t;
	typedef logic [7:0] reg_data_t;
	typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// ---- logic/uart_ctl_if.sv ----
// Purpose: register access and power link between controller and serial port
// Assumes: one clock, req answered by ack one cycle later
// Notes: no clocking block, testbench joins the ends here
`timescale 1ns/100ps
interface uart_ctl_if
(
	input wire logic hclk,
	input wire logic hresetn
);
	import uart_baud_pkg::*;
	logic req;
	logic wr;
	logic bitop;
	reg_addr_t addr;
	reg_data_t wdata;
	logic ack;
	reg_data_t rdata;
	logic sleep_enter;
	logic wake;

	modport device_end
	(
		input hclk, hresetn, req, wr, bitop, addr, wdata, sleep_enter,
		output ack, rdata, wake
	);
	modport host_end
	(
		input hclk, hresetn, ack, rdata, wake,
		output req, wr, bitop, addr, wdata, sleep_enter
	);
endinterface // uart_ctl_if

// ---- logic/reload_counter.sv ----
// Purpose: down counter that reloads at zero and pulses once per reload
// Assumes: step is a one-cycle enable
// Notes: period is reload+1 steps
`timescale 1ns/100ps
module reload_counter
#(
	parameter int WIDTH = 11
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic step,
	input wire logic stop,
	input wire logic [WIDTH-1:0] reload,
	output logic tick
);
	logic [WIDTH-1:0] count;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			count <= '0;
			tick <= 1'b0;
		end
		else if (stop)
		begin
			count <= '0;
			tick <= 1'b0;
		end
		else if (step && count == '0)
		begin
			count <= reload;
			tick <= 1'b1;
		end
		else
		begin
			if (step)
				count <= count - 1'b1;
			tick <= 1'b0;
		end
	end
endmodule // reload_counter

// ---- logic/uart_host_end.sv ----
// Purpose: controller end, turns AHB-Lite register writes into link accesses
// Assumes: single whole-word transfers, zero wait states
// Notes: one link access in flight, a command while busy is dropped
`timescale 1ns/100ps
`include "uart_baud_defines.svh"
module uart_host_end
(
	uart_ctl_if.host_end link,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	import uart_baud_pkg::*;

	logic ph_wr;
	logic [7:0] ph_addr;
	logic busy;
	logic wake_seen;
	logic addr_take;
	uart_baud_pkg::reg_data_t last_rdata;

	assign addr_take = hsel && htrans[1] && hreadyout;

	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
		begin
			ph_wr <= 1'b0;
			ph_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			ph_wr <= addr_take && hwrite;
			ph_addr <= haddr[7:0];
			if (addr_take && !hwrite && haddr[7:0] == `HOST_STATUS)
				hrdata <= {22'h000000, wake_seen, busy, last_rdata};
			else
				hrdata <= 32'h0000_0000;
		end
	end

	// Device answers with ack one cycle after req
	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
		begin
			link.req <= 1'b0;
			link.wr <= 1'b0;
			link.bitop <= 1'b0;
			link.addr <= 4'h0;
			link.wdata <= 8'h00;
			busy <= 1'b0;
			last_rdata <= 8'h00;
		end
		else
		begin
			link.req <= 1'b0;
			if (ph_wr && ph_addr == `HOST_CMD && !busy)
			begin
				link.req <= 1'b1;
				link.wr <= hwdata[`CMD_WRITE];
				link.bitop <= hwdata[`CMD_BITOP];
				link.addr <= hwdata[3:0];
				link.wdata <= hwdata[15:8];
				busy <= 1'b1;
			end
			else if (link.ack)
			begin
				busy <= 1'b0;
				if (!link.wr)
					last_rdata <= link.rdata;
			end
		end
	end

	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
			link.sleep_enter <= 1'b0;
		else
			link.sleep_enter <= ph_wr && ph_addr == `HOST_CTRL && hwdata[0];
	end

	// Wake report is sticky; a new wake beats the clear
	always_ff @(posedge link.hclk or negedge link.hresetn)
	begin
		if (!link.hresetn)
			wake_seen <= 1'b0;
		else if (link.wake)
			wake_seen <= 1'b1;
		else if (ph_wr && ph_addr == `HOST_STATUS && hwdata[`STAT_WAKE])
			wake_seen <= 1'b0;
	end
endmodule // uart_host_end

// ---- verif/uart_link_chk.sv ----
// Purpose: assertions on the control link between both ends
// Assumes: one clock domain, link signals only
// Notes: sleep and wake state rebuilt from link traffic
`timescale 1ns/100ps
module uart_link_chk
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic req,
	input wire logic wr,
	input wire logic bitop,
	input wire uart_baud_pkg::reg_addr_t addr,
	input wire uart_baud_pkg::reg_data_t wdata,
	input wire logic ack,
	input wire uart_baud_pkg::reg_data_t rdata,
	input wire logic sleep_enter,
	input wire logic wake
);
	import uart_baud_pkg::*;
	logic asleep;
	logic [1:0] wake_sel;
	logic fresh;
	logic rd_wr;
	reg_addr_t rd_addr;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			asleep <= 1'b0;
		else if (sleep_enter)
			asleep <= 1'b1;
		else if (wake)
			asleep <= 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			wake_sel <= 2'h0;
		else if (req && wr && addr == 4'h7)
			wake_sel[0] <= wdata[3];
		else if (req && wr && addr == 4'h8)
			wake_sel[1] <= wdata[3];

	// Tx empty is certain only until the holding register is written
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			fresh <= 1'b1;
		else if (sleep_enter)
			fresh <= 1'b1;
		else if (req && wr && addr == 4'h5)
			fresh <= 1'b0;

	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
		begin
			rd_wr <= 1'b1;
			rd_addr <= 4'h0;
		end
		else if (req)
		begin
			rd_wr <= wr;
			rd_addr <= addr;
		end

	ack_timing_a: assert property (req |=> ack ##1 !ack)
		else $error("ack not one cycle after request");
	ack_cause_a: assert property (ack |-> $past(req))
		else $error("ack without request");
	req_single_a: assert property (req |=> !req)
		else $error("request longer than one cycle");
	rdata_hold_a: assert property ($changed(rdata) |-> ack && !rd_wr)
		else $error("read data moved without a read");
	sleep_pulse_a: assert property (sleep_enter |=> !sleep_enter)
		else $error("sleep request too long");
	wake_pulse_a: assert property (wake |=> !wake)
		else $error("wake too long");
	wake_asleep_a: assert property (wake |-> asleep)
		else $error("wake while running");
	wake_source_a: assert property (wake |-> wake_sel == 2'h3)
		else $error("wake with input not selected");
	sleep_txempty_a: assert property (ack && !rd_wr && rd_addr == 4'h0 && fresh |-> rdata[0])
		else $error("tx empty flag clear");

	cover property (req && wr && bitop);
	cover property (wake);
	cover property (sleep_enter ##[1:20] ack);
endmodule // uart_link_chk

// ---- verif/test_uart_baud_attention_control.sv ----
// Purpose: self-checking bench for both serial port ends
// Assumes: 250 MHz hclk, AHB-Lite host with zero wait states
// Notes: bit times measured on the output pin in hclk cycles
`timescale 1ns/100ps
module test_uart_baud_attention_control;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic serial_input_pin;
	logic external_serial_clock_pin;
	logic serial_output_pin;
	logic rx_irq;
	logic tx_irq;
	logic [31:0] stat;
	logic [7:0] rdb;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;

	uart_ctl_if uart_ctl_if_i (.hclk(hclk), .hresetn(hresetn));
	uart_device_end uart_device_end_i (.link(uart_ctl_if_i.device_end), .serial_input_pin(serial_input_pin),
		.external_serial_clock_pin(external_serial_clock_pin), .serial_output_pin(serial_output_pin),
		.rx_irq(rx_irq), .tx_irq(tx_irq));
	uart_host_end uart_host_end_i (.link(uart_ctl_if_i.host_end), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
	uart_link_chk uart_link_chk_i (.hclk(hclk), .hresetn(hresetn), .req(uart_ctl_if_i.req),
		.wr(uart_ctl_if_i.wr), .bitop(uart_ctl_if_i.bitop), .addr(uart_ctl_if_i.addr),
		.wdata(uart_ctl_if_i.wdata), .ack(uart_ctl_if_i.ack), .rdata(uart_ctl_if_i.rdata),
		.sleep_enter(uart_ctl_if_i.sleep_enter), .wake(uart_ctl_if_i.wake));

	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			errors++;
			$display("mismatch at %0t: timeout", $time);
			end_sim;
		end
	end

	task automatic val_chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask

	task automatic pin_chk(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch at %0t: %s got %b", $time, what, got);
		end
	endtask

	task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask

	// Polls busy so no command is ever dropped
	task automatic dev(input logic [3:0] i, input logic w, input logic b, input logic [7:0] d,
		output logic [7:0] r);
		logic [31:0] s;
		ahb(32'h0, 1'b1, {14'h0, b, w, d, 4'h0, i}, s);
		s = 32'h100;
		while (s[8] !== 1'b0) ahb(32'h4, 1'b0, 32'h0, s);
		r = s[7:0];
	endtask

	task automatic wr(input logic [3:0] i, input logic [7:0] d);
		logic [7:0] r;
		dev(i, 1'b1, 1'b0, d, r);
	endtask

	task automatic rd(input logic [3:0] i, input logic [7:0] e, input string what);
		logic [7:0] r;
		dev(i, 1'b0, 1'b0, 8'h00, r);
		val_chk({24'h0, r}, {24'h0, e}, what);
	endtask

	// Sends 0xFF so only the start bit is low
	task automatic baud(input logic [4:0] code, input logic [2:0] hi, input logic [7:0] lo, input logic sync);
		int n;
		int exp;
		exp = (sync ? 2 : 16) * (int'({hi, lo}) + 1) * (int'(code) + 1) / 2;
		wr(4'h2, {5'h00, sync, 2'h0});
		wr(4'h3, 8'h00);
		wr(4'h4, lo);
		wr(4'h5, 8'hFF);
		repeat (100) @(posedge hclk);
		pin_chk(serial_output_pin, 1'b1, "stopped clock sent");
		n = 0;
		fork
			wr(4'h3, {hi, code});
			begin
				@(negedge serial_output_pin);
				@(negedge hclk);
				while (serial_output_pin === 1'b0)
				begin
					n++;
					@(negedge hclk);
				end
			end
		join
		val_chk(n, exp, "bit time");
		repeat (12 * exp) @(posedge hclk);
	endtask

	task automatic send(input logic [7:0] m, input logic [7:0] d);
		logic low;
		low = 1'b0;
		wr(4'h0, m);
		wr(4'h5, d);
		repeat (300)
		begin
			@(negedge hclk);
			low |= (serial_output_pin !== 1'b1);
		end
		pin_chk(low, 1'b0, "loopback drove line");
		@(posedge hclk);
	endtask

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		serial_input_pin = 1'b1;
		external_serial_clock_pin = 1'b0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(4'h0, 8'h01, "main reset");
		rd(4'h3, 8'h00, "prescale reset");
		baud(5'h01, 3'h0, 8'h00, 1'b0);
		baud(5'h01, 3'h0, 8'h01, 1'b0);
		baud(5'h02, 3'h0, 8'h01, 1'b0);
		baud(5'h03, 3'h0, 8'h02, 1'b0);
		baud(5'h1F, 3'h0, 8'h00, 1'b0);
		baud(5'h01, 3'h1, 8'h00, 1'b1);
		baud(5'h03, 3'h0, 8'h00, 1'b1);
		$display("baud done");
		wr(4'h2, 8'h00);
		wr(4'h3, 8'h00);
		wr(4'h4, 8'h00);
		wr(4'h3, 8'h01);
		send(8'h1C, 8'hA5);
		rd(4'h0, 8'h1F, "loop main");
		rd(4'h6, 8'hA5, "loop data");
		rd(4'h1, 8'h01, "loop ninth");
		$display("loopback done");
		wr(4'h1, 8'h08);
		send(8'h18, 8'h5A);
		rd(4'h0, 8'h19, "data dropped");
		rd(4'h1, 8'h09, "still waiting");
		send(8'h1C, 8'h3C);
		rd(4'h0, 8'h1F, "address full");
		wr(4'h2, 8'h01);
		pin_chk(rx_irq, 1'b1, "rx full irq");
		rd(4'h1, 8'h01, "wait cleared");
		rd(4'h6, 8'h3C, "address byte");
		send(8'h18, 8'h55);
		send(8'h18, 8'h66);
		rd(4'h1, 8'h04, "overrun");
		dev(4'h1, 1'b1, 1'b1, 8'h08, rdb);
		rd(4'h1, 8'h08, "errors cleared");
		$display("address wait done");
		wr(4'h7, 8'h08);
		wr(4'h8, 8'h08);
		serial_input_pin <= 1'b0;
		repeat (4) @(posedge hclk);
		serial_input_pin <= 1'b1;
		ahb(32'h4, 1'b0, 32'h0, stat);
		val_chk(stat & 32'h200, 32'h0, "wake while running");
		wr(4'h3, 8'h00);
		wr(4'h5, 8'h77);
		ahb(32'h8, 1'b1, 32'h1, stat);
		rd(4'h0, 8'h19, "sleep main");
		rd(4'h1, 8'h08, "sleep status");
		rd(4'h6, 8'h66, "rx kept");
		pin_chk(serial_output_pin, 1'b1, "sleep line");
		serial_input_pin <= 1'b0;
		repeat (4) @(posedge hclk);
		ahb(32'h4, 1'b0, 32'h0, stat);
		val_chk(stat & 32'h200, 32'h200, "start bit wake");
		serial_input_pin <= 1'b1;
		ahb(32'h4, 1'b1, 32'h200, stat);
		ahb(32'h4, 1'b0, 32'h0, stat);
		val_chk(stat & 32'h200, 32'h0, "wake cleared");
		$display("sleep done");
		wr(4'h0, 8'h00);
		// Internal chain is stopped, so only external edges can move the frame
		wr(4'h2, 8'h10);
		wr(4'h5, 8'h00);
		repeat (80) @(posedge hclk) external_serial_clock_pin <= ~external_serial_clock_pin;
		pin_chk(serial_output_pin, 1'b0, "external clock frame");
		repeat (320) @(posedge hclk) external_serial_clock_pin <= ~external_serial_clock_pin;
		pin_chk(serial_output_pin, 1'b1, "external clock end");
		$display("external clock done");
		wr(4'h2, 8'h0A);
		repeat (200) @(posedge hclk);
		pin_chk(serial_output_pin, 1'b0, "break held");
		pin_chk(tx_irq, 1'b1, "tx empty irq");
		wr(4'h2, 8'h00);
		repeat (4) @(posedge hclk);
		pin_chk(serial_output_pin, 1'b1, "break released");
		pin_chk(hresp, 1'b0, "okay response");
		$display("break done");
		end_sim;
	end
endmodule // test_uart_baud_attention_control
